// File: sim/arc_regs_sva.sv
// assertions on the audio routing register bank ports
// assumes binding onto arc_regs; one clock, async reset high
`timescale 1ns/1ns
`default_nettype none

module arc_regs_sva (
  // clock and reset
  input wire logic                        clk_sys,
  input wire logic                        reset,
  // bus
  input wire logic                        hsel,
  input wire logic [31:0]                 haddr,
  input wire logic [1:0]                  htrans,
  input wire logic                        hwrite,
  input wire logic                        hready,
  input wire logic                        hreadyout,
  input wire logic                        hresp,
  input wire logic [31:0]                 hrdata,
  // datapath
  input wire logic [arc_pkg::SAMPLE_W-1:0] mux1_data,
  input wire logic [arc_pkg::SAMPLE_W-1:0] downmix_left,
  input wire logic [arc_pkg::SAMPLE_W-1:0] downmix_in1,
  input wire logic [arc_pkg::SAMPLE_W-1:0] proc_ch1,
  input wire logic [arc_pkg::NUM_PWM-1:0]  pwm_chan,
  input wire logic                        headphone_left_pwm_pin,
  input wire logic                        subwoofer_pos_pwm,
  input wire arc_pkg::arc_am_cfg_t        am_cfg,
  input wire arc_pkg::arc_loud_cfg_t      loud_cfg,
  input wire arc_pkg::arc_drc_cfg_t       drc_cfg
);
  import arc_pkg::*;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  wire logic take;
  wire logic mapped;
  assign take   = hsel && hready && htrans[1];
  assign mapped = haddr[9:2] inside {IDX_VOLUME_CFG, IDX_DOWNMIX_SEL,
                  IDX_AM_CTRL, IDX_PWM_ROUTE, IDX_LOUD_GINV,
                  IDX_LOUD_SCALE, IDX_DRC_CTRL};

  a_okay_resp: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_ready_high: assert property (hreadyout == 1'b1)
    else $error("slave inserted a wait state");
  a_unmapped_read: assert property (
    $past(take && !hwrite && !mapped) |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_idle_rdata: assert property (
    $past(!(take && !hwrite)) |-> hrdata == 32'h0)
    else $error("read data without a read");
  a_cfg_hold: assert property (
    !$past(take && hwrite, 2) |-> $stable(drc_cfg) && $stable(loud_cfg))
    else $error("config moved without a write");
  a_am_hold: assert property (
    !$past(take && hwrite, 3) |-> $stable(am_cfg))
    else $error("am config moved without a write");
  a_dmx_gate: assert property (!$past(reset) |->
    downmix_in1 == $past(mux1_data) || downmix_in1 == '0)
    else $error("downmix feed neither data nor zero");
  a_ch1_src: assert property (!$past(reset) |->
    proc_ch1 == $past(mux1_data) || proc_ch1 == $past(downmix_left))
    else $error("channel 1 source wrong");
  a_pin_zero: assert property ($past(pwm_chan) == 6'h00 |->
    !headphone_left_pwm_pin && !subwoofer_pos_pwm)
    else $error("pin high with all channels low");

endmodule : arc_regs_sva

bind arc_regs arc_regs_sva u_sva (
  .clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .mux1_data, .downmix_left,
  .downmix_in1, .proc_ch1, .pwm_chan, .headphone_left_pwm_pin,
  .subwoofer_pos_pwm, .am_cfg, .loud_cfg, .drc_cfg
);

`default_nettype wire

// File: sim/tb.sv
// self-checking bench for the audio routing register bank
// assumes one clock; the bench is the only AHB-Lite master
`timescale 1ns/1ns
`default_nettype none

module tb;
  import arc_pkg::*;

  localparam logic [7:0] IDX_L [7] = '{IDX_VOLUME_CFG, IDX_DOWNMIX_SEL,
    IDX_AM_CTRL, IDX_PWM_ROUTE, IDX_LOUD_GINV, IDX_LOUD_SCALE, IDX_DRC_CTRL};
  localparam logic [31:0] RST_L [7] = '{32'h0, 32'h203, 32'h0,
    32'h0102_1345, 32'h0, 32'h0, 32'h0};
  // every field but AM D16 set, reserved bits zero and no reserved codes
  localparam logic [31:0] WR_L [7] = '{32'h40, 32'h1903, 32'h001e_1999,
    32'h5555_5555, 32'h03ff_ffff, 32'h03ff_ffff, 32'hf};

  logic                clk_sys = 1'b0;
  logic                reset = 1'b1;
  logic                hsel = 1'b0;
  logic                hwrite = 1'b0;
  logic [1:0]          htrans = 2'h0;
  logic [2:0]          hsize = 3'h2;
  logic [31:0]         haddr = 32'h0;
  logic [31:0]         hwdata = 32'h0;
  logic [5:0]          pwm_chan = 6'h15;
  logic [SAMPLE_W-1:0] mux1_data = '0, mux2_data = '0, ch6_data = '0;
  logic [SAMPLE_W-1:0] bass_data = '0, downmix_left = '0, downmix_right = '0;
  wire logic           hready;
  wire logic [31:0]    hrdata;
  wire logic [SAMPLE_W-1:0] downmix_in1, downmix_in2;
  wire logic [SAMPLE_W-1:0] proc_ch1, proc_ch2, proc_ch6;
  wire logic [7:0]     pins;
  arc_am_cfg_t         am_cfg;
  arc_loud_cfg_t       loud_cfg;
  arc_drc_cfg_t        drc_cfg;
  logic [31:0]         d;
  int                  failures = 0;
  int                  cmp_count = 0;
  int                  cycles = 0;

  arc_regs DUT (
    .clk_sys, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout(hready), .hresp(), .hrdata, .mux1_data, .mux2_data,
    .ch6_data, .bass_data, .downmix_left, .downmix_right, .downmix_in1,
    .downmix_in2, .proc_ch1, .proc_ch2, .proc_ch6, .pwm_chan,
    .headphone_left_pwm_pin(pins[7]), .headphone_right_pwm_pin(pins[6]),
    .out_a_pwm(pins[5]), .out_b_pwm(pins[4]), .out_c_pwm(pins[3]),
    .out_d_pwm(pins[2]), .subwoofer_neg_pwm(pins[1]),
    .subwoofer_pos_pwm(pins[0]), .am_cfg, .loud_cfg, .drc_cfg
  );

  always #2 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      test_done();
    end
  end

  function automatic logic [31:0] ad(input logic [7:0] i);
    return {22'h0, i, 2'b00};
  endfunction : ad

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // address phase held until hready, then data phase until hready
  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(a, 1'b1, v, x);
    repeat (2) @(posedge clk_sys);
  endtask : wr

  task automatic t_reset;
    for (int i = 0; i < 7; i++) begin
      bus(ad(IDX_L[i]), 1'b0, 32'h0, d);
      chk(d, RST_L[i]);
    end
    chk(pins, 8'hb2);
    chk(am_cfg, 16'h0);
  endtask : t_reset

  task automatic dmx(input logic [31:0] cfg,
                     input logic [SAMPLE_W-1:0] e1, e2, e6, i1, i2);
    wr(ad(IDX_DOWNMIX_SEL), cfg);
    chk(proc_ch1, e1);
    chk(proc_ch2, e2);
    chk(proc_ch6, e6);
    chk(downmix_in1, i1);
    chk(downmix_in2, i2);
  endtask : dmx

  task automatic t_dmx;
    mux1_data <= 24'h111111;
    mux2_data <= 24'h222222;
    ch6_data <= 24'h666666;
    bass_data <= 24'h0b0b0b;
    downmix_left <= 24'he00000;
    downmix_right <= 24'h100000;
    dmx(32'h1800, 24'he00000, 24'h100000, 24'h666666, 24'h0, 24'h0);
    dmx(32'h0103, 24'h111111, 24'h222222, 24'h0b0b0b, 24'h111111, 24'h222222);
    // signed mean of -0x200000 and 0x100000
    dmx(32'h0201, 24'h111111, 24'h222222, 24'hf80000, 24'h111111, 24'h0);
    dmx(32'h0002, 24'h111111, 24'h222222, 24'h666666, 24'h0, 24'h222222);
  endtask : t_dmx

  task automatic t_pwm;
    for (int c = 0; c < 6; c++) begin
      pwm_chan <= 6'h01 << c;
      wr(ad(IDX_PWM_ROUTE), {1'b0, 3'(c), 1'b0, 3'(c), {6{4'(c)}}});
      chk(pins, 8'hff);
    end
    pwm_chan <= 6'h15;
    wr(ad(IDX_PWM_ROUTE), 32'h5401_2345);
    chk(pins, 8'h6a);
    pwm_chan <= 6'h00;
    repeat (2) @(posedge clk_sys);
    chk(pins, 8'h00);
  endtask : t_pwm

  task automatic t_am;
    wr(ad(IDX_AM_CTRL), 32'h0016_1530);
    chk(am_cfg, {1'b1, 2'b01, 1'b1, 1'b0, 11'd1530});
    wr(ad(IDX_AM_CTRL), 32'h0019_07ff);
    chk(am_cfg, {1'b1, 2'b10, 1'b0, 1'b1, 11'h7ff});
    wr(ad(IDX_AM_CTRL), 32'h000e_0999);
    chk(am_cfg, {1'b0, 2'b11, 1'b1, 1'b0, 11'd999});
  endtask : t_am

  task automatic t_loud;
    wr(ad(IDX_VOLUME_CFG), 32'h0000_0040);
    wr(ad(IDX_LOUD_GINV), 32'h0123_4567);
    wr(ad(IDX_LOUD_SCALE), 32'h02ab_cdef);
    wr(ad(IDX_DRC_CTRL), 32'h0000_0005);
    chk(loud_cfg, {1'b1, 26'h1234567, 26'h2abcdef});
    chk(drc_cfg, 4'b1010);
    wr(ad(IDX_VOLUME_CFG), 32'h0000_0000);
    wr(ad(IDX_DRC_CTRL), 32'h0000_000a);
    chk(loud_cfg, {1'b0, 26'h1234567, 26'h2abcdef});
    chk(drc_cfg, 4'b0101);
  endtask : t_loud

  // write then read of one word with no idle cycle between them
  task automatic t_b2b;
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= ad(IDX_DRC_CTRL);
    hwrite <= 1'b1;
    htrans <= 2'h2;
    do @(posedge clk_sys); while (hready !== 1'b1);
    hwrite <= 1'b0;
    hwdata <= 32'h0000_0003;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 2'h0;
    do @(posedge clk_sys); while (hready !== 1'b1);
    chk(hrdata, 32'h0000_0003);
  endtask : t_b2b

  task automatic t_mask;
    wr(32'h0000_0100, 32'hffff_ffff);
    bus(32'h0000_0100, 1'b0, 32'h0, d);
    chk(d, 32'h0);
    for (int i = 0; i < 7; i++) begin
      wr(ad(IDX_L[i]), WR_L[i]);
      bus(ad(IDX_L[i]), 1'b0, 32'h0, d);
      chk(d, WR_L[i]);
    end
  endtask : t_mask

  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    t_dmx();
    t_pwm();
    t_am();
    t_loud();
    t_b2b();
    t_mask();
    // second reset after writes must restore defaults
    pwm_chan <= 6'h15;
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    t_reset();
    test_done();
  end

endmodule : tb

`default_nettype wire

// File: src/arc_pkg.sv
// Functional notes
// [R01] D12 set: channel 1 takes downmix left
// [R02] D11 set: channel 2 takes downmix right
// [R03] D9..D8 pick channel 6 source, 11 reserved
// [R04] D0 gates input mux 1 into downmix
// [R05] D1 gates input mux 2 into downmix
// [R06] AM enable D20, sequence D19..D18
// [R07] D17 picks 455 or 262.5 kHz IF
// [R08] D16 picks BCD or binary tuned frequency
// [R09] BCD digits at D12, D11..8, D7..4, D3..0
// [R10] binary tuned frequency is D10..D0
// [R11] pwm selector code is channel minus one
// [R12] headphone pins from D30..28 and D26..24
// [R13] outputs A, B from D23..20, D19..16
// [R14] outputs C, D from D15..12, D11..8
// [R15] sub pins from D7..4 and D3..0
// [R16] loudness compensation only when 0x0E D6 set
// [R17] gain inverse is signed 3.23 in 25..0
// [R18] loudness scale is signed 3.23 in 25..0
// [R19] D0 satellite, D1 sub compressor on
// [R20] D2, D3 tie satellite to channels 3, 4
// [R21] software writes zero to reserved bits
// [R22] reset gives defaults, reads return writes
//
// package of constants and carriers for the audio routing register bank.
// assumes a single AHB-Lite master and one clock for bus and datapath.
package arc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_VOLUME_CFG  = 8'h0e;
  localparam logic [7:0] IDX_DOWNMIX_SEL = 8'h21;
  localparam logic [7:0] IDX_AM_CTRL     = 8'h22;
  localparam logic [7:0] IDX_PWM_ROUTE   = 8'h25;
  localparam logic [7:0] IDX_LOUD_GINV   = 8'h26;
  localparam logic [7:0] IDX_LOUD_SCALE  = 8'h28;
  localparam logic [7:0] IDX_DRC_CTRL    = 8'h46;

  // writable bits of each register; the rest read as zero
  localparam logic [31:0] MASK_VOLUME_CFG  = 32'h0000_0040;
  localparam logic [31:0] MASK_DOWNMIX_SEL = 32'h0000_1b03;
  localparam logic [31:0] MASK_AM_CTRL     = 32'h001f_1fff;
  localparam logic [31:0] MASK_PWM_ROUTE   = 32'h77ff_ffff;
  localparam logic [31:0] MASK_LOUD        = 32'h03ff_ffff;
  localparam logic [31:0] MASK_DRC_CTRL    = 32'h0000_000f;

  // values after reset
  localparam logic [31:0] RST_VOLUME_CFG  = 32'h0000_0000;
  localparam logic [31:0] RST_DOWNMIX_SEL = 32'h0000_0203;
  localparam logic [31:0] RST_AM_CTRL     = 32'h0000_0000;
  localparam logic [31:0] RST_PWM_ROUTE   = 32'h0102_1345;
  localparam logic [31:0] RST_LOUD        = 32'h0000_0000;
  localparam logic [31:0] RST_DRC_CTRL    = 32'h0000_0000;

  // field positions
  localparam int BIT_LOUD_EN   = 6;
  localparam int BIT_DMX_CH1   = 12;
  localparam int BIT_DMX_CH2   = 11;
  localparam int LSB_CH6_SRC   = 8;
  localparam int BIT_DMX_FEED1 = 0;
  localparam int BIT_DMX_FEED2 = 1;
  localparam int BIT_AM_EN     = 20;
  localparam int LSB_AM_SEQ    = 18;
  localparam int BIT_AM_IF     = 17;
  localparam int BIT_AM_BIN    = 16;
  localparam int BIT_BCD_THOU  = 12;
  localparam int LSB_BCD_HUND  = 8;
  localparam int LSB_BCD_TENS  = 4;
  localparam int LSB_BCD_UNIT  = 0;
  localparam int BIT_DRC_SAT   = 0;
  localparam int BIT_DRC_SUB   = 1;
  localparam int BIT_DRC_DEP3  = 2;
  localparam int BIT_DRC_DEP4  = 3;

  // pin order: hp left, hp right, A, B, C, D, sub neg, sub pos
  localparam int NUM_PINS = 8;
  localparam int NUM_PWM  = 6;
  localparam int PIN_SEL_LSB [NUM_PINS] = '{28, 24, 20, 16, 12, 8, 4, 0};

  localparam int SAMPLE_W = 24;

  typedef enum logic [1:0] {
    CH6_OWN  = 2'b00,
    CH6_BASS = 2'b01,
    CH6_AVG  = 2'b10,
    CH6_RSVD = 2'b11
  } arc_ch6_src_t;

  typedef struct packed {
    logic        enable;
    logic [1:0]  sequence_sel;
    logic        if_262k5;
    logic        binary_code;
    logic [10:0] tuned_khz;
  } arc_am_cfg_t;

  typedef struct packed {
    logic        comp_en;
    logic [25:0] gain_inv;
    logic [25:0] scale;
  } arc_loud_cfg_t;

  typedef struct packed {
    logic sat_on;
    logic sub_on;
    logic sat_dep_ch3;
    logic sat_dep_ch4;
  } arc_drc_cfg_t;

endpackage : arc_pkg

// File: src/arc_regs.sv
// register bank for downmix, AM avoidance, pwm routing, loudness, drc.
// assumes AHB-Lite single word transfers; pwm and samples are on clk_sys.
`timescale 1ns/1ns
`default_nettype none

module arc_regs (
  // clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        reset,
  // ahb-lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  // samples into the downmix and processor channels
  input  wire logic [arc_pkg::SAMPLE_W-1:0] mux1_data,
  input  wire logic [arc_pkg::SAMPLE_W-1:0] mux2_data,
  input  wire logic [arc_pkg::SAMPLE_W-1:0] ch6_data,
  input  wire logic [arc_pkg::SAMPLE_W-1:0] bass_data,
  input  wire logic [arc_pkg::SAMPLE_W-1:0] downmix_left,
  input  wire logic [arc_pkg::SAMPLE_W-1:0] downmix_right,
  // samples out
  output logic [arc_pkg::SAMPLE_W-1:0]     downmix_in1,
  output logic [arc_pkg::SAMPLE_W-1:0]     downmix_in2,
  output logic [arc_pkg::SAMPLE_W-1:0]     proc_ch1,
  output logic [arc_pkg::SAMPLE_W-1:0]     proc_ch2,
  output logic [arc_pkg::SAMPLE_W-1:0]     proc_ch6,
  // internal pwm channels and output pins
  input  wire logic [arc_pkg::NUM_PWM-1:0] pwm_chan,
  output logic                             headphone_left_pwm_pin,
  output logic                             headphone_right_pwm_pin,
  output logic                             out_a_pwm,
  output logic                             out_b_pwm,
  output logic                             out_c_pwm,
  output logic                             out_d_pwm,
  output logic                             subwoofer_neg_pwm,
  output logic                             subwoofer_pos_pwm,
  // configuration to the processing datapath
  output arc_pkg::arc_am_cfg_t             am_cfg,
  output arc_pkg::arc_loud_cfg_t           loud_cfg,
  output arc_pkg::arc_drc_cfg_t            drc_cfg
);
  import arc_pkg::*;

  localparam int SW = SAMPLE_W;

  // address phase capture
  logic        wr_pend_q;
  logic [7:0]  wr_idx_q;
  logic        addr_ok;
  logic        acc_req;
  logic [7:0]  acc_idx;

  // stored registers
  logic [31:0] vol_cfg_q;
  logic [31:0] dmx_sel_q;
  logic [31:0] am_ctrl_q;
  logic [31:0] pwm_route_q;
  logic [31:0] loud_ginv_q;
  logic [31:0] loud_scale_q;
  logic [31:0] drc_ctrl_q;

  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  // datapath
  logic [SW-1:0] ch1_d;
  logic [SW-1:0] ch2_d;
  logic [SW-1:0] ch6_d;
  logic [SW-1:0] feed1_d;
  logic [SW-1:0] feed2_d;
  logic [SW:0]   avg_sum;
  arc_ch6_src_t  ch6_src;

  logic [NUM_PINS-1:0] pin_d;
  logic [NUM_PINS-1:0] pin_q;

  logic [10:0] khz_d;
  arc_am_cfg_t am_cfg_q;

  // selector code to pwm level; an unused code drives the pin low
  function automatic logic pwm_pick(
    input logic [3:0]         sel,
    input logic [NUM_PWM-1:0] chans
  );
    logic res;
    res = 1'b0;
    if (sel < 4'(NUM_PWM)) begin
      res = chans[sel[2:0]]; // [R11]
    end
    return res;
  endfunction : pwm_pick

  // writable bits of a register index; unmapped indices have none
  function automatic logic [31:0] wr_mask(input logic [7:0] idx);
    logic [31:0] m;
    m = 32'h0000_0000;
    unique case (idx)
      IDX_VOLUME_CFG:  m = MASK_VOLUME_CFG;
      IDX_DOWNMIX_SEL: m = MASK_DOWNMIX_SEL;
      IDX_AM_CTRL:     m = MASK_AM_CTRL;
      IDX_PWM_ROUTE:   m = MASK_PWM_ROUTE;
      IDX_LOUD_GINV:   m = MASK_LOUD;
      IDX_LOUD_SCALE:  m = MASK_LOUD;
      IDX_DRC_CTRL:    m = MASK_DRC_CTRL;
      default:         m = 32'h0000_0000;
    endcase
    return m;
  endfunction : wr_mask

  // bcd digits to kilohertz; digits above nine are taken as written
  function automatic logic [10:0] bcd_khz(input logic [31:0] r);
    logic [13:0] acc;
    acc = 14'd0;
    acc = acc + (r[BIT_BCD_THOU] ? 14'd1000 : 14'd0);
    acc = acc + 14'(r[LSB_BCD_HUND +: 4]) * 14'd100;
    acc = acc + 14'(r[LSB_BCD_TENS +: 4]) * 14'd10;
    acc = acc + 14'(r[LSB_BCD_UNIT +: 4]);
    return acc[10:0];
  endfunction : bcd_khz

  // bus
  // zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_q;

  assign acc_req = hsel & hready & htrans[1];
  assign acc_idx = haddr[9:2];
  // only word accesses at aligned addresses inside the index range
  assign addr_ok = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00)
                   && (hsize == 3'b010);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wr_pend_q <= 1'b0;
      wr_idx_q  <= 8'h00;
    end else begin
      if (hready) begin
        wr_pend_q <= acc_req & hwrite & addr_ok;
        wr_idx_q  <= acc_idx;
      end
    end
  end

  // read data is fetched in the address phase so it stands in the
  // data phase; a write still in its data phase has not landed, so it
  // is forwarded and a back-to-back read of that word sees new data
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (acc_req && !hwrite && addr_ok) begin
      unique case (acc_idx)
        IDX_VOLUME_CFG:  rdata_d = vol_cfg_q;
        IDX_DOWNMIX_SEL: rdata_d = dmx_sel_q;
        IDX_AM_CTRL:     rdata_d = am_ctrl_q;
        IDX_PWM_ROUTE:   rdata_d = pwm_route_q;
        IDX_LOUD_GINV:   rdata_d = loud_ginv_q;
        IDX_LOUD_SCALE:  rdata_d = loud_scale_q;
        IDX_DRC_CTRL:    rdata_d = drc_ctrl_q;
        default:         rdata_d = 32'h0000_0000;
      endcase
      if (wr_pend_q && (wr_idx_q == acc_idx)) begin
        rdata_d = hwdata & wr_mask(acc_idx); // [R22]
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      if (hready) begin
        rdata_q <= rdata_d; // [R22]
      end
    end
  end

  // register writes
  // reserved bits are dropped on write so they always read zero
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      vol_cfg_q    <= RST_VOLUME_CFG; // [R22]
      dmx_sel_q    <= RST_DOWNMIX_SEL;
      am_ctrl_q    <= RST_AM_CTRL;
      pwm_route_q  <= RST_PWM_ROUTE;
      loud_ginv_q  <= RST_LOUD;
      loud_scale_q <= RST_LOUD;
      drc_ctrl_q   <= RST_DRC_CTRL;
    end else begin
      if (wr_pend_q) begin
        unique case (wr_idx_q)
          IDX_VOLUME_CFG: begin
            vol_cfg_q <= hwdata & MASK_VOLUME_CFG; // [R16]
          end
          IDX_DOWNMIX_SEL: begin
            dmx_sel_q <= hwdata & MASK_DOWNMIX_SEL; // [R22]
          end
          IDX_AM_CTRL: begin
            am_ctrl_q <= hwdata & MASK_AM_CTRL; // [R09]
          end
          IDX_PWM_ROUTE: begin
            pwm_route_q <= hwdata & MASK_PWM_ROUTE; // [R12]
          end
          IDX_LOUD_GINV: begin
            loud_ginv_q <= hwdata & MASK_LOUD; // [R17]
          end
          IDX_LOUD_SCALE: begin
            loud_scale_q <= hwdata & MASK_LOUD; // [R18]
          end
          IDX_DRC_CTRL: begin
            drc_ctrl_q <= hwdata & MASK_DRC_CTRL; // [R19]
          end
          default: begin
          end
        endcase
      end
    end
  end

  // downmix feed and processor channel sources
  assign ch6_src = arc_ch6_src_t'(dmx_sel_q[LSB_CH6_SRC +: 2]);

  // signed average; the extra bit keeps the sum from wrapping
  assign avg_sum = {downmix_left[SW-1], downmix_left}
                 + {downmix_right[SW-1], downmix_right};

  always_comb begin
    feed1_d = dmx_sel_q[BIT_DMX_FEED1] ? mux1_data : '0; // [R04]
    feed2_d = dmx_sel_q[BIT_DMX_FEED2] ? mux2_data : '0; // [R05]
    ch1_d = dmx_sel_q[BIT_DMX_CH1] ? downmix_left : mux1_data; // [R01]
    ch2_d = dmx_sel_q[BIT_DMX_CH2] ? downmix_right : mux2_data; // [R02]
    unique case (ch6_src)
      CH6_OWN:  ch6_d = ch6_data; // [R03]
      CH6_BASS: ch6_d = bass_data;
      CH6_AVG:  ch6_d = avg_sum[SW:1];
      CH6_RSVD: ch6_d = '0; // silence on the reserved code
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      downmix_in1 <= '0;
      downmix_in2 <= '0;
      proc_ch1    <= '0;
      proc_ch2    <= '0;
      proc_ch6    <= '0;
    end else begin
      downmix_in1 <= feed1_d;
      downmix_in2 <= feed2_d;
      proc_ch1    <= ch1_d;
      proc_ch2    <= ch2_d;
      proc_ch6    <= ch6_d;
    end
  end

  // pwm routing
  // headphone fields are three bits wide; their top bit is masked off
  // at write, so a four bit slice is safe for every pin
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    assign pin_d[p] = pwm_pick(
      pwm_route_q[PIN_SEL_LSB[p] +: 4], pwm_chan); // [R13] [R14] [R15]
  end

  // one flop of delay on every pin keeps their relative timing equal
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pin_q <= '0;
    end else begin
      pin_q <= pin_d;
    end
  end

  assign headphone_left_pwm_pin  = pin_q[0]; // [R12]
  assign headphone_right_pwm_pin = pin_q[1];
  assign out_a_pwm               = pin_q[2];
  assign out_b_pwm               = pin_q[3];
  assign out_c_pwm               = pin_q[4];
  assign out_d_pwm               = pin_q[5];
  assign subwoofer_neg_pwm       = pin_q[6];
  assign subwoofer_pos_pwm       = pin_q[7];

  // AM avoidance settings
  always_comb begin
    if (am_ctrl_q[BIT_AM_BIN]) begin
      khz_d = am_ctrl_q[10:0]; // [R10]
    end else begin
      khz_d = bcd_khz(am_ctrl_q); // [R08] [R09]
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      am_cfg_q <= '0;
    end else begin
      am_cfg_q.enable       <= am_ctrl_q[BIT_AM_EN]; // [R06]
      am_cfg_q.sequence_sel <= am_ctrl_q[LSB_AM_SEQ +: 2];
      am_cfg_q.if_262k5     <= am_ctrl_q[BIT_AM_IF]; // [R07]
      am_cfg_q.binary_code  <= am_ctrl_q[BIT_AM_BIN];
      am_cfg_q.tuned_khz    <= khz_d;
    end
  end

  assign am_cfg = am_cfg_q;

  // loudness and compressor settings come straight from registers
  assign loud_cfg.comp_en  = vol_cfg_q[BIT_LOUD_EN]; // [R16]
  assign loud_cfg.gain_inv = loud_ginv_q[25:0]; // [R17]
  assign loud_cfg.scale    = loud_scale_q[25:0]; // [R18]

  assign drc_cfg.sat_on      = drc_ctrl_q[BIT_DRC_SAT]; // [R19]
  assign drc_cfg.sub_on      = drc_ctrl_q[BIT_DRC_SUB];
  assign drc_cfg.sat_dep_ch3 = drc_ctrl_q[BIT_DRC_DEP3]; // [R20]
  assign drc_cfg.sat_dep_ch4 = drc_ctrl_q[BIT_DRC_DEP4];

endmodule : arc_regs

`default_nettype wire
